// File: hdl/usic_pkg.sv
// constants, register map and state types of the serial status and interrupt block
package usic_pkg;
	// ---------------------------------------------------------------
	// bus
	// ---------------------------------------------------------------
	localparam int          DATA_W      = 32;
	localparam int          ADDR_W      = 32;
	localparam logic [2:0]  HSIZE_WORD  = 3'h2;
	localparam logic [1:0]  HRESP_OKAY  = 2'h0;
	// register indices, byte address is index * 4
	localparam logic [7:0]  IDX_CTRL    = 8'h98;
	localparam logic [7:0]  IDX_DATA    = 8'h99;
	localparam logic [7:0]  IDX_AUX     = 8'hA2;
	localparam logic [7:0]  IDX_STATUS  = 8'hBA;
	localparam logic [7:0]  IDX_BAUD    = 8'hBE;
	// ---------------------------------------------------------------
	// uart_status_control fields
	// ---------------------------------------------------------------
	localparam int          ST_IRQ_EN   = 0;
	localparam int          ST_OE       = 1;
	localparam int          ST_LOW      = 2;
	localparam int          ST_FRAME    = 3;
	localparam int          ST_DRAIN    = 4;
	localparam int          ST_SPLIT    = 5;
	localparam int          ST_LATE     = 6;
	localparam int          ST_DOUBLE   = 7;
	// serial control fields
	localparam int          CT_RX_DONE  = 0;
	localparam int          CT_TX_DONE  = 1;
	localparam int          CT_RX9      = 2;
	localparam int          CT_TX9      = 3;
	localparam int          CT_REN      = 4;
	localparam int          CT_MODE_LO  = 6;
	localparam int          CT_MODE_HI  = 7;
	// aux fields
	localparam int          AX_DOUBLE   = 0;
	localparam int          AX_EBRK     = 6;
	// reset values
	localparam logic [7:0]  RST_BAUD    = 8'h00;
	localparam logic [7:0]  RST_CTRL    = 8'h00;
	// ---------------------------------------------------------------
	// modes and timing
	// ---------------------------------------------------------------
	localparam logic [1:0]  MODE_SHIFT  = 2'h0;
	localparam logic [1:0]  MODE_8VAR   = 2'h1;
	localparam logic [1:0]  MODE_9FIX   = 2'h2;
	localparam logic [1:0]  MODE_9VAR   = 2'h3;
	localparam logic [3:0]  OS_LAST     = 4'hF;
	localparam logic [3:0]  OS_SMP_A    = 4'h6;
	localparam logic [3:0]  OS_SMP_B    = 4'h7;
	localparam logic [3:0]  OS_SMP_C    = 4'h8;
	localparam logic [3:0]  BITS_8      = 4'h7;
	localparam logic [3:0]  BITS_9      = 4'h8;
	localparam int          BREAK_BITS  = 11;
	localparam logic [7:0]  BREAK_TICKS = 8'(BREAK_BITS * 16);
	localparam logic [7:0]  OS_DIV_FIX32 = 8'h01;
	localparam logic [7:0]  OS_DIV_FAST  = 8'h00;
	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usic_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usic_rx_t;
endpackage : usic_pkg

// File: hdl/usic_uart_status_and_irq_control.sv
// serial port with status flags, interrupt routing and transmit double buffering
// How it works
// - mode select 00 shift register at clock/16 after reset, 01/11 variable, 10 fixed.
// - status enable lets framing, break and overrun flags raise the serial interrupt.
// - status interrupt rides the receive line when split, the combined line otherwise.
// - receive done flag raises its interrupt whatever the status enable says.
// - break with break reset enable set requests a device reset.
// - overrun set when bit 8 arrives while receive done still set; software clears.
// - break flag set after 11 low bit times; only software clears it.
// - framing flag set when the stop bit is low; only software clears it.
// - double buffered, select 1: one interrupt per character plus one when drained.
// - double buffered, select 0: exactly one interrupt per character written.
// - double buffered, first character into an empty buffer interrupts at once, later ones per placement.
// - split select gives separate receive and transmit interrupts, else one combined.
// - transmit interrupt at start of stop bit, or its end when late placement set; in shift mode 00 at end of the eighth data bit.
// - double buffer enable bit, cleared by reset.
// - single buffered with late placement may leave a gap before next start.
// - double buffered write into empty buffer loads shifter and interrupts at once.
module usic_uart_status_and_irq_control
	import usic_pkg::*;
(
	// clock and reset
	input  wire logic                           hclk,
	input  wire logic                           hresetn,
	// ahb-lite slave
	input  wire logic                           hsel,
	input  wire logic [usic_pkg::ADDR_W-1:0]    haddr,
	input  wire logic [1:0]                     htrans,
	input  wire logic                           hwrite,
	input  wire logic [2:0]                     hsize,
	input  wire logic [usic_pkg::DATA_W-1:0]    hwdata,
	input  wire logic                           hready,
	output logic      [usic_pkg::DATA_W-1:0]    hrdata,
	output logic                                hreadyout,
	output logic      [1:0]                     hresp,
	// serial line
	input  wire logic                           rxd,
	output logic                                txd,
	// interrupts and reset request
	output logic                                irq_rx,
	output logic                                irq_tx,
	output logic                                break_reset_req
);
	import usic_pkg::*;

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	logic       ph_wr;
	logic [7:0] ph_idx;
	logic [7:0] rd_idx;
	logic [7:0] rd_val;
	logic [7:0] wdat;
	logic       addr_ok;
	logic       wr_ctrl, wr_data, wr_aux, wr_status, wr_baud;

	assign addr_ok   = hsel & hready & htrans[1];
	assign rd_idx    = (haddr[ADDR_W-1:10] == '0) ? haddr[9:2] : 8'h00;
	assign wdat      = hwdata[7:0];
	assign wr_ctrl   = ph_wr & (ph_idx == IDX_CTRL);
	assign wr_data   = ph_wr & (ph_idx == IDX_DATA);
	assign wr_aux    = ph_wr & (ph_idx == IDX_AUX);
	assign wr_status = ph_wr & (ph_idx == IDX_STATUS);
	assign wr_baud   = ph_wr & (ph_idx == IDX_BAUD);
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr  <= 1'b0;
			ph_idx <= 8'h00;
		end else begin
			ph_wr  <= addr_ok & hwrite & (hsize == HSIZE_WORD);
			ph_idx <= rd_idx;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic       dbl_buf_enable, tx_irq_late, split_irq_select, dbl_buf_irq_select, status_irq_enable;
	logic       framing_error_flag, line_low_flag, overrun_flag;
	logic       receive_done_flag, transmit_done_flag, rx_ninth_bit, tx_ninth_bit, rx_enable;
	logic       mode_sel_hi, mode_sel_lo, break_reset_enable, double_rate;
	logic [7:0] baud_div, rx_buffer;
	logic [1:0] mode;
	logic       frame_set, low_set, oe_set, rx_done_set, tx_done_set;

	assign mode = {mode_sel_hi, mode_sel_lo};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dbl_buf_enable     <= 1'b0;
			tx_irq_late        <= 1'b0;
			split_irq_select   <= 1'b0;
			dbl_buf_irq_select <= 1'b0;
			status_irq_enable  <= 1'b0;
		end else if (wr_status) begin
			dbl_buf_enable     <= wdat[ST_DOUBLE];
			tx_irq_late        <= wdat[ST_LATE];
			split_irq_select   <= wdat[ST_SPLIT];
			dbl_buf_irq_select <= wdat[ST_DRAIN];
			status_irq_enable  <= wdat[ST_IRQ_EN];
		end
	end

	// hardware set wins over a software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			framing_error_flag <= 1'b0;
			line_low_flag      <= 1'b0;
			overrun_flag       <= 1'b0;
		end else begin
			framing_error_flag <= frame_set | (framing_error_flag & ~(wr_status & ~wdat[ST_FRAME]));
			line_low_flag      <= low_set | (line_low_flag & ~(wr_status & ~wdat[ST_LOW]));
			overrun_flag       <= oe_set | (overrun_flag & ~(wr_status & ~wdat[ST_OE]));
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{mode_sel_hi, mode_sel_lo} <= MODE_SHIFT;
			tx_ninth_bit               <= 1'b0;
			rx_enable                  <= 1'b0;
		end else if (wr_ctrl) begin
			{mode_sel_hi, mode_sel_lo} <= {wdat[CT_MODE_HI], wdat[CT_MODE_LO]};
			tx_ninth_bit               <= wdat[CT_TX9];
			rx_enable                  <= wdat[CT_REN];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			receive_done_flag  <= 1'b0;
			transmit_done_flag <= 1'b0;
		end else begin
			receive_done_flag  <= rx_done_set | (wr_ctrl ? wdat[CT_RX_DONE] : receive_done_flag);
			transmit_done_flag <= tx_done_set | (wr_ctrl ? wdat[CT_TX_DONE] : transmit_done_flag);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			break_reset_enable <= 1'b0;
			double_rate        <= 1'b0;
			baud_div           <= RST_BAUD;
		end else begin
			if (wr_aux) begin
				break_reset_enable <= wdat[AX_EBRK];
				double_rate        <= wdat[AX_DOUBLE];
			end
			if (wr_baud)
				baud_div <= wdat;
		end
	end

	always_comb begin
		unique case (rd_idx)
			IDX_CTRL:   rd_val = {mode_sel_hi, mode_sel_lo, 1'b0, rx_enable, tx_ninth_bit, rx_ninth_bit,
			                      transmit_done_flag, receive_done_flag};
			IDX_DATA:   rd_val = rx_buffer;
			IDX_AUX:    rd_val = {1'b0, break_reset_enable, 5'h00, double_rate};
			IDX_STATUS: rd_val = {dbl_buf_enable, tx_irq_late, split_irq_select, dbl_buf_irq_select,
			                      framing_error_flag, line_low_flag, overrun_flag, status_irq_enable};
			IDX_BAUD:   rd_val = baud_div;
			default:    rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= '0;
		else if (addr_ok & ~hwrite)
			hrdata <= {24'h000000, rd_val};
	end

	// ---------------------------------------------------------------
	// oversampling tick, 16 per bit
	// ---------------------------------------------------------------
	logic [7:0] os_cnt, os_limit;
	logic       os_tick;

	always_comb begin
		unique case (mode)
			MODE_SHIFT: os_limit = OS_DIV_FAST;
			MODE_9FIX:  os_limit = double_rate ? OS_DIV_FAST : OS_DIV_FIX32;
			MODE_8VAR,
			MODE_9VAR:  os_limit = baud_div;
		endcase
	end

	assign os_tick = (os_cnt >= os_limit);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			os_cnt <= 8'h00;
		else
			os_cnt <= os_tick ? 8'h00 : os_cnt + 8'h01;
	end

	// ---------------------------------------------------------------
	// transmitter with one holding stage
	// ---------------------------------------------------------------
	usic_tx_t   tx_state;
	logic [3:0] tx_os, tx_bit, tx_last;
	logic [8:0] tx_shift, hold_data;
	logic       hold_valid, hold_irq_given;
	logic       tx_bit_end, stop_begin, stop_end, tx_point, tx_idle_empty, load_now, hold_now;

	assign tx_last       = (mode[1]) ? BITS_9 : BITS_8;
	assign tx_bit_end    = os_tick & (tx_os == OS_LAST);
	assign stop_begin    = (tx_state == TX_DATA) & tx_bit_end & (tx_bit == tx_last) & (mode != MODE_SHIFT);
	assign stop_end      = (tx_state == TX_STOP) & tx_bit_end;
	assign tx_point      = tx_irq_late ? stop_end : stop_begin;
	assign tx_idle_empty = (tx_state == TX_IDLE) & ~hold_valid;
	assign load_now      = wr_data & tx_idle_empty;
	assign hold_now      = wr_data & dbl_buf_enable & (tx_state != TX_IDLE) & ~hold_valid;

	always_comb begin
		if (mode == MODE_SHIFT)
			tx_done_set = (tx_state == TX_DATA) & tx_bit_end & (tx_bit == BITS_8);
		else if (dbl_buf_enable)
			tx_done_set = load_now
			            | (tx_point & hold_valid & ~hold_irq_given)
			            | (stop_end & hold_valid & ~hold_irq_given)
			            | (tx_point & ~hold_valid & dbl_buf_irq_select);
		else
			tx_done_set = tx_point;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state <= TX_IDLE;
			tx_os    <= 4'h0;
			tx_bit   <= 4'h0;
			tx_shift <= 9'h1FF;
		end else begin
			if (tx_state != TX_IDLE && os_tick)
				tx_os <= tx_os + 4'h1;
			unique case (tx_state)
				TX_IDLE: if (load_now) begin
					tx_shift <= {tx_ninth_bit, wdat};
					tx_os    <= 4'h0;
					tx_bit   <= 4'h0;
					tx_state <= (mode == MODE_SHIFT) ? TX_DATA : TX_START;
				end
				TX_START: if (tx_bit_end)
					tx_state <= TX_DATA;
				TX_DATA: if (tx_bit_end) begin
					tx_shift <= {1'b1, tx_shift[8:1]};
					tx_bit   <= tx_bit + 4'h1;
					if (mode == MODE_SHIFT && tx_bit == BITS_8)
						tx_state <= TX_IDLE;
					else if (tx_bit == tx_last)
						tx_state <= TX_STOP;
				end
				TX_STOP: if (tx_bit_end) begin
					tx_bit <= 4'h0;
					if (hold_valid) begin
						tx_shift <= hold_data; // back to back, one stop bit between
						tx_state <= TX_START;
					end else
						tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_valid     <= 1'b0;
			hold_irq_given <= 1'b0;
			hold_data      <= 9'h000;
		end else if (hold_now) begin
			hold_valid     <= 1'b1;
			hold_irq_given <= 1'b0;
			hold_data      <= {tx_ninth_bit, wdat};
		end else if (stop_end) begin
			hold_valid     <= 1'b0;
			hold_irq_given <= 1'b0;
		end else if (tx_point & hold_valid)
			hold_irq_given <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			txd <= 1'b1;
		else begin
			unique case (tx_state)
				TX_IDLE:  txd <= 1'b1;
				TX_START: txd <= 1'b0;
				TX_DATA:  txd <= tx_shift[0];
				TX_STOP:  txd <= 1'b1;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// receiver, majority of three samples per bit
	// ---------------------------------------------------------------
	usic_rx_t   rx_state;
	logic       rxd_meta, rxd_sync, rxd_prev, smp_a, smp_b, rx_val, rx_dec, break_hold, nine;
	logic [3:0] rx_os, rx_bit;
	logic [8:0] rx_shift;
	logic [7:0] low_cnt;

	assign nine   = mode[1];
	assign rx_val = (smp_a & smp_b) | (smp_a & rxd_sync) | (smp_b & rxd_sync);
	assign rx_dec = os_tick & (rx_os == OS_SMP_C) & (rx_state != RX_IDLE);
	assign low_set = os_tick & ~rxd_sync & rx_enable & (low_cnt == BREAK_TICKS - 8'h01);
	assign oe_set = rx_dec & receive_done_flag &
	                (((rx_state == RX_DATA) & nine & (rx_bit == BITS_9)) | ((rx_state == RX_STOP) & ~nine));
	assign frame_set   = rx_dec & (rx_state == RX_STOP) & ~rx_val;
	assign rx_done_set = rx_dec & (rx_state == RX_STOP) & ~receive_done_flag;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			rxd_prev <= 1'b1;
		end else begin
			rxd_meta <= rxd;
			rxd_sync <= rxd_meta;
			rxd_prev <= rxd_sync;
		end
	end

	// break counter and receiver hold-off until the line goes high again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_cnt    <= 8'h00;
			break_hold <= 1'b0;
		end else begin
			if (rxd_sync)
				low_cnt <= 8'h00;
			else if (os_tick && low_cnt != BREAK_TICKS)
				low_cnt <= low_cnt + 8'h01;
			if (low_set)
				break_hold <= 1'b1;
			else if (rxd_sync)
				break_hold <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state <= RX_IDLE;
			rx_os    <= 4'h0;
			rx_bit   <= 4'h0;
			rx_shift <= 9'h000;
			smp_a    <= 1'b1;
			smp_b    <= 1'b1;
		end else if (!rx_enable || mode == MODE_SHIFT) begin
			rx_state <= RX_IDLE;
		end else begin
			if (rx_state != RX_IDLE && os_tick) begin
				rx_os <= rx_os + 4'h1;
				if (rx_os == OS_SMP_A)
					smp_a <= rxd_sync;
				if (rx_os == OS_SMP_B)
					smp_b <= rxd_sync;
			end
			unique case (rx_state)
				RX_IDLE: if (rxd_prev && !rxd_sync && !break_hold) begin
					rx_os    <= 4'h0; // restart the bit counter on the edge
					rx_bit   <= 4'h0;
					rx_state <= RX_START;
				end
				RX_START: if (rx_dec)
					rx_state <= rx_val ? RX_IDLE : RX_DATA; // false start rejected
				RX_DATA: if (rx_dec) begin
					rx_shift <= {rx_val, rx_shift[8:1]};
					rx_bit   <= rx_bit + 4'h1;
					if (rx_bit == (nine ? BITS_9 : BITS_8))
						rx_state <= RX_STOP;
				end
				RX_STOP: if (rx_dec)
					rx_state <= RX_IDLE;
			endcase
		end
	end

	// frame is dropped while receive done is still set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_buffer    <= 8'h00;
			rx_ninth_bit <= 1'b0;
		end else if (rx_done_set) begin
			rx_buffer    <= nine ? rx_shift[7:0] : rx_shift[8:1];
			rx_ninth_bit <= nine ? rx_shift[8] : rx_val;
		end
	end

	// ---------------------------------------------------------------
	// interrupt routing and break reset
	// ---------------------------------------------------------------
	logic status_irq;

	assign status_irq = status_irq_enable & (framing_error_flag | line_low_flag | overrun_flag);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_rx          <= 1'b0;
			irq_tx          <= 1'b0;
			break_reset_req <= 1'b0;
		end else begin
			if (split_irq_select) begin
				irq_rx <= receive_done_flag | status_irq;
				irq_tx <= transmit_done_flag;
			end else begin
				irq_rx <= receive_done_flag | transmit_done_flag | status_irq;
				irq_tx <= 1'b0;
			end
			break_reset_req <= low_set & break_reset_enable;
		end
	end
endmodule : usic_uart_status_and_irq_control

// File: tb/test_usic_uart_status_and_irq_control.sv
// self-checking bench for the serial status and interrupt block
`define CHK(a, e) begin \
	tests_run++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("mismatch at %0t got %0h expected %0h", $time, (a), (e)); \
	end \
end
module test_usic_uart_status_and_irq_control;
	timeunit 1ns;
	timeprecision 100ps;
	import usic_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout;
	logic        rxd, txd, irq_rx, irq_tx, break_reset_req;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, hresp;
	logic [2:0]  hsize;
	int          bad_count, tests_run, brk_n, b0;
	assign hready = hreadyout;
	usic_uart_status_and_irq_control dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .rxd, .txd, .irq_rx, .irq_tx, .break_reset_req);
	usic_node node (.hclk, .rxd, .txd);
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) if (break_reset_req === 1'b1) brk_n++;
	// ------------------------------------------
	// bus and wait tasks
	// ------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	task automatic tmo();
		bad_count++;
		end_of_test();
	endtask : tmo
	task automatic rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			if (++n > 50) tmo();
			@(posedge hclk);
		end
	endtask : rdy
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {22'h0, i, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= HSIZE_WORD;
		rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		rdy();
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, i, d, r);
	endtask : wr
	task automatic rdc(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] r;
		bus(1'b0, i, 8'h00, r);
		`CHK(r & {24'hFFFFFF, m}, {24'h0, e})
	endtask : rdc
	task automatic wait_tx(input int lim, output int n);
		n = 0;
		while (irq_tx !== 1'b1) begin
			@(posedge hclk);
			n++;
			if (n > lim) tmo();
		end
	endtask : wait_tx
	// ------------------------------------------
	// transfer scenarios
	// ------------------------------------------
	task automatic tx(input logic [1:0] m, input logic lt, input int bt, input int nb, input logic [8:0] d);
		logic [8:0] q;
		logic       ok;
		int         n, e;
		e = (m == MODE_SHIFT) ? 8 * bt : (1 + nb + lt) * bt;
		wr(IDX_CTRL, {m, 2'b00, d[8], 3'b000}); // ninth bit before data
		wr(IDX_STATUS, {1'b0, lt, 6'h20}); // no double buffer here
		fork
			if (nb > 0) node.get(q, ok, nb, bt);
			begin
				wr(IDX_DATA, d[7:0]);
				wait_tx(800, n);
			end
		join
		`CHK(n >= e && n <= e + 6, 1'b1)
		if (nb > 0) begin
			`CHK(q, d & 9'((1 << nb) - 1))
			`CHK(ok, 1'b1)
		end
		repeat (64) @(posedge hclk);
	endtask : tx
	task automatic db(input logic sel);
		logic [8:0] q1, q2;
		logic       k1, k2;
		int         n;
		wr(IDX_CTRL, 8'h40);
		wr(IDX_STATUS, {3'b101, sel, 4'h0});
		fork
			begin
				node.get(q1, k1, 8, 16);
				node.get(q2, k2, 8, 16);
			end
			begin
				wr(IDX_DATA, 8'h11);
				wait_tx(8, n);
				`CHK(n <= 6, 1'b1)
				wr(IDX_CTRL, 8'h40);
				wr(IDX_DATA, 8'h22);
				wait_tx(400, n);
				wr(IDX_CTRL, 8'h40);
				repeat (400) @(posedge hclk);
				`CHK(irq_tx, sel)
			end
		join
		`CHK({q1, q2, k1, k2}, {9'h011, 9'h022, 2'b11})
	endtask : db
	initial begin
		repeat (100000) @(posedge hclk);
		tmo();
	end
	initial begin
		hresetn = 1'b0;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'h0;
		hwrite  = 1'b0;
		hsize   = HSIZE_WORD;
		hwdata  = 32'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(IDX_STATUS, 8'hFF, 8'h00);
		rdc(IDX_CTRL, 8'hFF, RST_CTRL);
		rdc(IDX_BAUD, 8'hFF, RST_BAUD);
		wr(8'h00, 8'h5A);
		rdc(8'h00, 8'hFF, 8'h00);
		`CHK(hresp, HRESP_OKAY)
		tx(MODE_SHIFT, 1'b0, 16, 0, 9'h0A5);
		tx(MODE_8VAR, 1'b0, 16, 8, 9'h13C);
		tx(MODE_8VAR, 1'b1, 16, 8, 9'h0C3);
		tx(MODE_9FIX, 1'b0, 32, 9, 9'h15A);
		wr(IDX_AUX, 8'h01);
		tx(MODE_9FIX, 1'b0, 16, 9, 9'h0B4);
		wr(IDX_AUX, 8'h00);
		tx(MODE_9VAR, 1'b1, 16, 9, 9'h1E1);
		// receive, overrun and interrupt routing
		wr(IDX_CTRL, 8'h50);
		wr(IDX_STATUS, 8'h00);
		node.send(9'h03C, 8, 1'b1, 16);
		repeat (4) @(posedge hclk);
		`CHK(irq_rx, 1'b1)
		rdc(IDX_DATA, 8'hFF, 8'h3C);
		node.send(9'h05A, 8, 1'b1, 16);
		rdc(IDX_STATUS, 8'h0E, 8'h02);
		wr(IDX_CTRL, 8'h50);
		repeat (4) @(posedge hclk);
		`CHK(irq_rx, 1'b0)
		wr(IDX_STATUS, 8'h0F);
		repeat (4) @(posedge hclk);
		`CHK(irq_rx, 1'b1)
		wr(IDX_STATUS, 8'h2F);
		repeat (4) @(posedge hclk);
		`CHK({irq_rx, irq_tx}, 2'b10)
		wr(IDX_STATUS, 8'h2D);
		rdc(IDX_STATUS, 8'h0E, 8'h00);
		`CHK(irq_rx, 1'b0)
		// ten low bit times: framing only
		node.send(9'h000, 8, 1'b0, 16);
		rdc(IDX_STATUS, 8'h0E, 8'h08);
		wr(IDX_STATUS, 8'h20);
		wr(IDX_CTRL, 8'h50);
		wr(IDX_AUX, 8'h40);
		b0 = brk_n;
		node.brk(12 * 16);
		repeat (40) @(posedge hclk);
		rdc(IDX_STATUS, 8'h0C, 8'h0C);
		`CHK(brk_n - b0, 1)
		wr(IDX_AUX, 8'h00);
		wr(IDX_STATUS, 8'h20);
		rdc(IDX_STATUS, 8'hFF, 8'h20);
		db(1'b0);
		db(1'b1);
		end_of_test();
	end
endmodule : test_usic_uart_status_and_irq_control

// File: tb/usic_assertions.sv
// checker for readback, transmit start and break request at the serial block ports
module usic_chk
	import usic_pkg::*;
(
	// clock and reset
	input wire logic                        hclk,
	input wire logic                        hresetn,
	// register bus
	input wire logic                        hsel,
	input wire logic [usic_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0]                  htrans,
	input wire logic                        hwrite,
	input wire logic [2:0]                  hsize,
	input wire logic [usic_pkg::DATA_W-1:0] hwdata,
	input wire logic                        hready,
	input wire logic [usic_pkg::DATA_W-1:0] hrdata,
	// line and requests
	input wire logic                        rxd,
	input wire logic                        txd,
	input wire logic                        irq_tx,
	input wire logic                        break_reset_req
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       ap_wr;
	logic [7:0] ap_idx;
	logic [3:0] cfg;
	logic [1:0] mode;
	logic       ebrk;
	logic [7:0] idle_cnt;
	logic [7:0] low_cnt;
	logic       dw;
	// ------------------------------------------
	// shadow of written configuration
	// ------------------------------------------
	assign dw = ap_wr && ap_idx == IDX_DATA;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr  <= 1'b0;
			ap_idx <= 8'h00;
		end else begin
			ap_wr  <= hsel && hready && htrans[1] && hwrite && hsize == HSIZE_WORD;
			ap_idx <= haddr[9:2];
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg  <= 4'h0;
			mode <= 2'h0;
			ebrk <= 1'b0;
		end else if (ap_wr) begin
			if (ap_idx == IDX_STATUS) cfg <= hwdata[7:4];
			if (ap_idx == IDX_CTRL) mode <= hwdata[7:6];
			if (ap_idx == IDX_AUX) ebrk <= hwdata[AX_EBRK];
		end
	end
	// idle line and low line run lengths
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_cnt <= 8'h00;
			low_cnt  <= 8'h00;
		end else begin
			idle_cnt <= (dw || !txd) ? 8'h00 : idle_cnt + {7'h0, idle_cnt != 8'hFF};
			low_cnt  <= rxd ? 8'h00 : low_cnt + {7'h0, low_cnt != 8'hFF};
		end
	end
	// ------------------------------------------
	// properties
	// ------------------------------------------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence bus_rd(i);
		hsel && hready && htrans[1] && !hwrite && haddr[9:2] == i;
	endsequence
	// data write into a transmitter idle for 40 cycles
	sequence tx_load;
		dw && mode != MODE_SHIFT && idle_cnt >= 8'h28;
	endsequence
	status_cfg_a: assert property (bus_rd(IDX_STATUS) |=> hrdata[7:4] == $past(cfg) && hrdata[31:8] == 0)
		else $error("status readback differs from written setup");
	mode_read_a: assert property (bus_rd(IDX_CTRL) |=> hrdata[7:6] == $past(mode))
		else $error("mode readback differs from written mode");
	tx_start_a: assert property (tx_load |-> ##[1:3] !txd)
		else $error("no start bit after data write");
	db_first_a: assert property (tx_load and cfg[3] && cfg[1] |-> ##[1:4] irq_tx)
		else $error("no prompt transmit interrupt on empty buffer");
	split_tx_a: assert property (irq_tx |-> cfg[1] || $past(cfg[1]))
		else $error("transmit line used while combined");
	brk_pulse_a: assert property ($rose(break_reset_req) |=> !break_reset_req)
		else $error("reset request longer than one cycle");
	brk_gate_a: assert property (break_reset_req |-> ebrk)
		else $error("reset request while break reset disabled");
	brk_low_a: assert property (break_reset_req |-> low_cnt >= 8'hB0)
		else $error("reset request before 11 low bit times");
endmodule : usic_chk

bind usic_uart_status_and_irq_control usic_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hrdata, .rxd, .txd, .irq_tx, .break_reset_req);

// File: tb/usic_node.sv
// remote serial node: frame sender and receiver on the line
module usic_node (
	// clock
	input wire logic hclk,
	// line
	output logic     rxd,
	input wire logic txd
);
	timeunit 1ns;
	timeprecision 100ps;
	// line idles high between frames
	initial rxd = 1'b1;
	task automatic send(input logic [8:0] d, input int nb, input logic stp, input int bt);
		@(posedge hclk);
		rxd <= 1'b0;
		repeat (bt) @(posedge hclk);
		for (int i = 0; i < nb; i++) begin
			rxd <= d[i];
			repeat (bt) @(posedge hclk);
		end
		rxd <= stp;
		repeat (bt) @(posedge hclk);
		rxd <= 1'b1;
	endtask : send
	task automatic brk(input int n);
		@(posedge hclk);
		rxd <= 1'b0;
		repeat (n) @(posedge hclk);
		rxd <= 1'b1;
	endtask : brk
	// lsb first, samples mid bit, ok low on missing start or stop
	task automatic get(output logic [8:0] d, output logic ok, input int nb, input int bt);
		int n;
		n = 0;
		d = 9'h000;
		while (txd !== 1'b0 && n < 4000) begin
			@(posedge hclk);
			n++;
		end
		repeat (bt / 2) @(posedge hclk);
		ok = n < 4000 && txd === 1'b0;
		for (int i = 0; i < nb; i++) begin
			repeat (bt) @(posedge hclk);
			d[i] = txd;
		end
		repeat (bt) @(posedge hclk);
		ok = ok && txd === 1'b1;
	endtask : get
endmodule : usic_node
